// ### host_port_interface_bench.sv
`timescale 1ns/1ps
module host_port_interface_bench;
  logic mclk, reset, half_mode, use_as, cmd_valid, cmd_ready, cmd_write, rsp_valid;
  logic [1:0] cmd_ctl;
  logic [31:0] cmd_data, rsp_data, rd_addr, rd_data, wr_addr, wr_data, mem_word;
  logic [31:0] got, seen_wr_data, seen_wr_addr;
  logic rd_req, rd_ack, wr_valid, wr_ready, wr_en;
  int failures = 0;
  int cmp_count = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int ack_wait = 0;

  hpp_if hpp_if_i ();
  hpp_device hpp_device_i (.mclk(mclk), .reset(reset), .bus(hpp_if_i),
    .halfword_bus_mode(half_mode), .dma_rd_req(rd_req), .dma_rd_addr(rd_addr),
    .dma_rd_ack(rd_ack), .dma_rd_data(rd_data), .dma_wr_valid(wr_valid),
    .dma_wr_ready(wr_ready), .dma_wr_addr(wr_addr), .dma_wr_data(wr_data));
  hpp_host hpp_host_i (.mclk(mclk), .reset(reset), .bus(hpp_if_i),
    .halfword_bus_mode(half_mode), .use_address_strobe(use_as), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_ctl(cmd_ctl), .cmd_write(cmd_write), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hpp_assertions hpp_assertions_i (.mclk(mclk), .reset(reset),
    .host_chip_select_n(hpp_if_i.host_chip_select_n),
    .host_data_strobe_a(hpp_if_i.host_data_strobe_a),
    .host_data_strobe_b(hpp_if_i.host_data_strobe_b),
    .host_address_strobe_n(hpp_if_i.host_address_strobe_n),
    .access_control_field(hpp_if_i.access_control_field),
    .host_read_write(hpp_if_i.host_read_write), .halfword_select(hpp_if_i.halfword_select),
    .host_data_oe(hpp_if_i.host_data_oe), .dev_data_oe(hpp_if_i.dev_data_oe),
    .host_ready_n(hpp_if_i.host_ready_n));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // memory side, slow answer so ready must wait for the load
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    wr_ready <= wr_en;
    if (rd_req && !rd_ack && ack_wait >= 5) begin
      rd_ack <= 1'b1;
      rd_data <= mem_word;
      ack_wait <= 0;
    end else begin
      rd_ack <= 1'b0;
      rd_data <= ~mem_word;
      if (rd_req && !rd_ack) ack_wait <= ack_wait + 1;
    end
    if (rd_req && rd_ack) rd_cnt <= rd_cnt + 1;
    if (wr_valid && wr_ready) begin
      wr_cnt <= wr_cnt + 1;
      seen_wr_data <= wr_data;
      seen_wr_addr <= wr_addr;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask : chk

  task automatic give_up(input string what);
    $display("Error %s expected response seen timeout", what);
    failures++;
    test_done();
  endtask : give_up

  task automatic run_cmd(input logic [1:0] ctl, input logic wr, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_ctl <= ctl;
    cmd_write <= wr;
    cmd_data <= d;
    n = 0;
    do begin @(posedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    if (n >= 50) give_up("command accept");
    n = 0;
    do begin @(posedge mclk); n++; end while (rsp_valid !== 1'b1 && n < 300);
    if (n >= 300) give_up("command response");
    r = rsp_data;
  endtask : run_cmd

  task automatic wait_wr(input int target);
    int n;
    n = 0;
    while (wr_cnt < target && n < 50) begin @(posedge mclk); n++; end
    chk("write count", target, wr_cnt);
  endtask : wait_wr

  // ----------------------------------------------------------------
  // scenario: idle outputs right after reset
  // ----------------------------------------------------------------
  task automatic s_reset;
    @(posedge mclk);
    chk("ready after reset", 32'h0000_0001, {31'h0, hpp_if_i.host_ready_n});
    chk("device drive after reset", 32'h0000_0000, {31'h0, hpp_if_i.dev_data_oe});
  endtask : s_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_word(input logic as);
    logic [31:0] base;
    int r0, w0;
    base = {19'h00000, as, 12'h100};
    use_as <= as;
    half_mode <= 1'b0;
    mem_word <= 32'h1234_5678;
    run_cmd(hpp_pkg::CTL_ADDRESS, 1'b1, base, got);
    run_cmd(hpp_pkg::CTL_CONTROL, 1'b1, 32'h0000_00a5, got);
    run_cmd(hpp_pkg::CTL_CONTROL, 1'b0, 32'h0000_0000, got);
    chk("control readback", 32'h0000_00a5, got);
    w0 = wr_cnt;
    run_cmd(hpp_pkg::CTL_DATA, 1'b1, 32'hcafe_0001, got);
    wait_wr(w0 + 1);
    chk("write data", 32'hcafe_0001, seen_wr_data);
    chk("write addr", base, seen_wr_addr);
    r0 = rd_cnt;
    run_cmd(hpp_pkg::CTL_DATA, 1'b0, 32'h0000_0000, got);
    chk("read word", 32'h1234_5678, got);
    chk("fetch count", r0 + 1, rd_cnt);
    chk("fetch addr", base, rd_addr);
    run_cmd(hpp_pkg::CTL_DATA_INC, 1'b0, 32'h0000_0000, got);
    run_cmd(hpp_pkg::CTL_ADDRESS, 1'b0, 32'h0000_0000, got);
    chk("address step", base + hpp_pkg::ADDR_STEP, got);
  endtask : s_word

  task automatic s_half;
    int r0, w0;
    half_mode <= 1'b1;
    use_as <= 1'b1;
    mem_word <= 32'h89ab_cdef;
    r0 = rd_cnt;
    run_cmd(hpp_pkg::CTL_DATA, 1'b0, 32'h0000_0000, got);
    chk("half read word", 32'h89ab_cdef, got);
    chk("half fetch count", r0 + 1, rd_cnt);
    w0 = wr_cnt;
    run_cmd(hpp_pkg::CTL_DATA, 1'b1, 32'h5566_7788, got);
    wait_wr(w0 + 1);
    chk("half write word", 32'h5566_7788, seen_wr_data);
  endtask : s_half

  // buffer stays full while memory stalls, so the second write must wait
  task automatic s_full;
    int w0;
    half_mode <= 1'b0;
    use_as <= 1'b0;
    wr_en <= 1'b0;
    w0 = wr_cnt;
    run_cmd(hpp_pkg::CTL_DATA, 1'b1, 32'h0bad_0001, got);
    fork
      run_cmd(hpp_pkg::CTL_DATA, 1'b1, 32'h0bad_0002, got);
      begin
        repeat (40) @(posedge mclk);
        chk("stalled writes", w0, wr_cnt);
        chk("not ready while full", 32'h0000_0001, {31'h0, hpp_if_i.host_ready_n});
        wr_en <= 1'b1;
      end
    join
    wait_wr(w0 + 2);
    chk("last write", 32'h0bad_0002, seen_wr_data);
  endtask : s_full

  initial begin
    reset = 1'b1;
    half_mode = 1'b0;
    use_as = 1'b0;
    cmd_valid = 1'b0;
    cmd_ctl = 2'h0;
    cmd_write = 1'b0;
    cmd_data = 32'h0000_0000;
    wr_en = 1'b1;
    mem_word = 32'h0000_0000;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    s_reset();
    s_word(1'b0);
    s_word(1'b1);
    s_half();
    s_full();
    test_done();
  end
endmodule : host_port_interface_bench

// ### hpp_assertions.sv
`timescale 1ns/1ps
module hpp_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic host_chip_select_n,
  input wire logic host_data_strobe_a,
  input wire logic host_data_strobe_b,
  input wire logic host_address_strobe_n,
  input wire logic [1:0] access_control_field,
  input wire logic host_read_write,
  input wire logic halfword_select,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic host_ready_n
);
  // ----------------------------------------------------------------
  // combined strobe, active low
  // ----------------------------------------------------------------
  logic stb_n;
  assign stb_n = ~(host_data_strobe_a ^ host_data_strobe_b) | host_chip_select_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // ready only inside an access or the short release tail
  property p_ready_in_access;
    !host_ready_n |-> !(stb_n && $past(stb_n, 1) && $past(stb_n, 2) && $past(stb_n, 3)
      && $past(stb_n, 4) && $past(stb_n, 5));
  endproperty
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready low with no access strobe");

  property p_not_ready_at_start;
    $fell(stb_n) |-> host_ready_n [*3];
  endproperty
  a_not_ready_at_start: assert property (p_not_ready_at_start)
    else $error("ready low too early in access");

  property p_hold_until_ready;
    !stb_n && host_ready_n |=> !stb_n;
  endproperty
  a_hold_until_ready: assert property (p_hold_until_ready)
    else $error("strobe released before ready");

  property p_gap_min;
    $rose(stb_n) |-> stb_n [*4];
  endproperty
  a_gap_min: assert property (p_gap_min)
    else $error("strobe high gap too short");

  property p_low_min;
    $fell(stb_n) |-> !stb_n [*4];
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("strobe low pulse too short");

  property p_one_addr_pulse;
    $fell(host_address_strobe_n) |=> host_address_strobe_n [*8];
  endproperty
  a_one_addr_pulse: assert property (p_one_addr_pulse)
    else $error("address strobe pulsed twice");

  property p_select_stable;
    !stb_n && $past(!stb_n) |->
      $stable({access_control_field, host_read_write, halfword_select});
  endproperty
  a_select_stable: assert property (p_select_stable)
    else $error("select inputs changed in access");

  // device drives only a read answer, never against the host
  property p_read_drive;
    dev_data_oe |-> !host_ready_n && host_read_write && !host_data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("device data drive outside read answer");
endmodule : hpp_assertions

// ### hpp_device.sv
// Functional notes
// - access strobe is not(a xor b) or select
// - host holds strobe until ready goes low
// - host pulses address strobe once per access
// - read fetch at strobe fall, ready after load
// - write not ready while write buffer full
// - latch control field, rw and half select
// - host keeps strobe high four clocks between
// - host keeps strobe low four clocks minimum
`timescale 1ns/1ps
module hpp_device (
  input wire logic mclk,
  input wire logic reset,
  hpp_if.dev bus,
  input wire logic halfword_bus_mode,
  output logic dma_rd_req,
  output logic [31:0] dma_rd_addr,
  input wire logic dma_rd_ack,
  input wire logic [31:0] dma_rd_data,
  output logic dma_wr_valid,
  input wire logic dma_wr_ready,
  output logic [31:0] dma_wr_addr,
  output logic [31:0] dma_wr_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [31:0] dat_s1;
  logic [31:0] dat_s2;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_s1 <= hpp_pkg::PIN_IDLE;
      pin_s2 <= hpp_pkg::PIN_IDLE;
      dat_s1 <= hpp_pkg::WORD_RESET;
      dat_s2 <= hpp_pkg::WORD_RESET;
    end else begin
      pin_s1 <= {bus.host_chip_select_n, bus.host_data_strobe_a, bus.host_data_strobe_b,
                 bus.host_address_strobe_n, bus.host_read_write, bus.halfword_select,
                 bus.access_control_field};
      pin_s2 <= pin_s1;
      dat_s1 <= bus.host_data_bus;
      dat_s2 <= dat_s1;
    end
  end

  // ----------------------------------------------------------------
  // strobe forming and edges
  // ----------------------------------------------------------------
  logic strobe_n;
  logic strobe_d;
  logic as_d;
  logic stb_fall;
  logic as_fall;

  assign strobe_n = ~(pin_s2[6] ^ pin_s2[5]) | pin_s2[7];
  assign stb_fall = strobe_d & ~strobe_n;
  assign as_fall = as_d & ~pin_s2[4];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_d <= 1'b1;
      as_d <= 1'b1;
    end else begin
      strobe_d <= strobe_n;
      as_d <= pin_s2[4];
    end
  end

  // ----------------------------------------------------------------
  // select latch
  // ----------------------------------------------------------------
  logic held;
  logic lat_rw;
  logic lat_hws;
  logic [1:0] lat_ctl;
  logic cur_rw;
  logic cur_hws;
  logic [1:0] cur_ctl;

  // a second address strobe in the same access is ignored
  // address strobe first
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      held <= 1'b0;
      lat_rw <= 1'b0;
      lat_hws <= 1'b0;
      lat_ctl <= hpp_pkg::CTL_CONTROL;
    end else if (strobe_n & strobe_d & held & ~as_fall) begin
      held <= held;
    end else if ((as_fall | stb_fall) & ~held) begin
      held <= 1'b1;
      lat_rw <= pin_s2[3];
      lat_hws <= pin_s2[2];
      lat_ctl <= pin_s2[1:0];
    end else if (strobe_n & ~strobe_d) begin
      held <= 1'b0;
    end
  end

  assign cur_rw = held ? lat_rw : pin_s2[3];
  assign cur_hws = held ? lat_hws : pin_s2[2];
  assign cur_ctl = held ? lat_ctl : pin_s2[1:0];

  logic is_data;
  logic second_half;
  logic complete;

  assign is_data = cur_ctl[hpp_pkg::CTL_DATA_BIT];
  assign second_half = halfword_bus_mode & cur_hws;
  assign complete = ~halfword_bus_mode | cur_hws;

  // ----------------------------------------------------------------
  // access state machine
  // ----------------------------------------------------------------
  hpp_pkg::hpp_dev_state_t state;
  hpp_pkg::hpp_dev_state_t next_state;
  logic wr_full;

  always_comb begin
    next_state = state;
    case (state)
      hpp_pkg::HPP_ST_IDLE: begin
        if (stb_fall) begin
          if (cur_rw & is_data & ~second_half) begin
            next_state = hpp_pkg::HPP_ST_FETCH;
          end else if (~cur_rw & is_data & complete & wr_full) begin
            next_state = hpp_pkg::HPP_ST_WAIT_WR;
          end else begin
            next_state = hpp_pkg::HPP_ST_READY;
          end
        end
      end
      hpp_pkg::HPP_ST_FETCH: begin
        if (dma_rd_ack) begin
          next_state = hpp_pkg::HPP_ST_READY;
        end
      end
      hpp_pkg::HPP_ST_WAIT_WR: begin
        if (~wr_full) begin
          next_state = hpp_pkg::HPP_ST_READY;
        end
      end
      hpp_pkg::HPP_ST_READY: begin
        // access ends only on strobe release
        if (strobe_n) begin
          next_state = hpp_pkg::HPP_ST_IDLE;
        end
      end
      default: begin
        next_state = hpp_pkg::HPP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= hpp_pkg::HPP_ST_IDLE;
      bus.host_ready_n <= 1'b1;
      dma_rd_req <= 1'b0;
    end else begin
      state <= next_state;
      bus.host_ready_n <= (next_state != hpp_pkg::HPP_ST_READY);
      dma_rd_req <= (next_state == hpp_pkg::HPP_ST_FETCH);
    end
  end

  // ----------------------------------------------------------------
  // registers and write buffer
  // ----------------------------------------------------------------
  logic [31:0] data_reg;
  logic [31:0] addr_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] half_hold;
  logic [31:0] wr_word;
  logic finish;
  logic wr_push;

  assign wr_word = halfword_bus_mode ? {dat_s2[15:0], half_hold} : dat_s2;
  // data is sampled when the released strobe is seen, with equal sync delay
  assign finish = (state == hpp_pkg::HPP_ST_READY) & strobe_n;
  assign wr_push = finish & ~cur_rw & is_data & complete;
  assign dma_rd_addr = addr_reg;
  assign dma_wr_valid = wr_full;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      half_hold <= 16'h0000;
      ctrl_reg <= hpp_pkg::WORD_RESET;
    end else if (finish & ~cur_rw & ~complete) begin
      half_hold <= dat_s2[15:0];
    end else if (finish & ~cur_rw & (cur_ctl == hpp_pkg::CTL_CONTROL)) begin
      ctrl_reg <= wr_word;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_reg <= hpp_pkg::WORD_RESET;
    end else if (finish & ~cur_rw & (cur_ctl == hpp_pkg::CTL_ADDRESS) & complete) begin
      addr_reg <= wr_word;
    end else if (finish & is_data & complete & (cur_ctl == hpp_pkg::CTL_DATA_INC)) begin
      addr_reg <= addr_reg + hpp_pkg::ADDR_STEP;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      data_reg <= hpp_pkg::WORD_RESET;
    end else if ((state == hpp_pkg::HPP_ST_FETCH) & dma_rd_ack) begin
      data_reg <= dma_rd_data;
    end else if (wr_push) begin
      data_reg <= wr_word;
    end
  end

  // buffer full flag, fill wins over drain
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_full <= 1'b0;
      dma_wr_addr <= hpp_pkg::WORD_RESET;
      dma_wr_data <= hpp_pkg::WORD_RESET;
    end else begin
      wr_full <= wr_push | (wr_full & ~dma_wr_ready);
      if (wr_push) begin
        dma_wr_addr <= addr_reg;
        dma_wr_data <= wr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data drive
  // ----------------------------------------------------------------
  logic [31:0] rd_src;
  logic [31:0] rd_val;

  always_comb begin
    case (cur_ctl)
      hpp_pkg::CTL_CONTROL: rd_src = ctrl_reg;
      hpp_pkg::CTL_ADDRESS: rd_src = addr_reg;
      // second half reuses the held word
      default: rd_src = (state == hpp_pkg::HPP_ST_FETCH) ? dma_rd_data : data_reg;
    endcase
    if (~halfword_bus_mode) begin
      rd_val = rd_src;
    end else if (cur_hws) begin
      rd_val = {16'h0000, rd_src[31:16]};
    end else begin
      rd_val = {16'h0000, rd_src[15:0]};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.dev_data_out <= hpp_pkg::WORD_RESET;
      bus.dev_data_oe <= 1'b0;
    end else begin
      if ((next_state == hpp_pkg::HPP_ST_READY) & (state != hpp_pkg::HPP_ST_READY)) begin
        bus.dev_data_out <= rd_val;
      end
      bus.dev_data_oe <= (next_state == hpp_pkg::HPP_ST_READY) & cur_rw;
    end
  end

endmodule : hpp_device

// ### hpp_host.sv
`timescale 1ns/1ps
module hpp_host (
  input wire logic mclk,
  input wire logic reset,
  hpp_if.host bus,
  input wire logic halfword_bus_mode,
  input wire logic use_address_strobe,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_ctl,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_data,
  output logic rsp_valid,
  output logic [31:0] rsp_data
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic rdy_s1;
  logic rdy_s2;
  logic [31:0] dat_s1;
  logic [31:0] dat_s2;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
      dat_s1 <= hpp_pkg::WORD_RESET;
      dat_s2 <= hpp_pkg::WORD_RESET;
    end else begin
      rdy_s1 <= bus.host_ready_n;
      rdy_s2 <= rdy_s1;
      dat_s1 <= bus.host_data_bus;
      dat_s2 <= dat_s1;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  hpp_pkg::hpp_host_state_t state;
  logic [3:0] cnt;
  logic half;
  logic [31:0] word;

  assign cmd_ready = (state == hpp_pkg::HPP_H_IDLE);
  // strobe b stays high, so strobe a low makes the combined strobe active
  assign bus.host_data_strobe_b = 1'b1;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= hpp_pkg::HPP_H_IDLE;
      cnt <= 4'h0;
      half <= 1'b0;
      word <= hpp_pkg::WORD_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= hpp_pkg::WORD_RESET;
      bus.host_chip_select_n <= 1'b1;
      bus.host_data_strobe_a <= 1'b1;
      bus.host_address_strobe_n <= 1'b1;
      bus.access_control_field <= hpp_pkg::CTL_CONTROL;
      bus.host_read_write <= 1'b0;
      bus.halfword_select <= 1'b0;
      bus.host_data_out <= hpp_pkg::WORD_RESET;
      bus.host_data_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        hpp_pkg::HPP_H_IDLE: begin
          if (cmd_valid) begin
            bus.access_control_field <= cmd_ctl;
            bus.host_read_write <= ~cmd_write;
            word <= cmd_data;
            half <= 1'b0;
            state <= hpp_pkg::HPP_H_SETUP;
          end
        end
        hpp_pkg::HPP_H_SETUP: begin
          bus.host_chip_select_n <= 1'b0;
          bus.halfword_select <= half;
          bus.host_address_strobe_n <= ~use_address_strobe;
          bus.host_data_oe <= ~bus.host_read_write;
          bus.host_data_out <= (halfword_bus_mode & half) ? {16'h0000, word[31:16]} :
                               (halfword_bus_mode ? {16'h0000, word[15:0]} : word);
          bus.host_data_strobe_a <= 1'b0;
          cnt <= 4'h0;
          state <= hpp_pkg::HPP_H_LOW;
        end
        hpp_pkg::HPP_H_LOW: begin
          bus.host_address_strobe_n <= 1'b1;
          if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
          end
          if ((cnt >= 4'(hpp_pkg::STB_LOW_CYC - 1)) & ~rdy_s2) begin
            bus.host_data_strobe_a <= 1'b1;
            if (bus.host_read_write) begin
              if (~halfword_bus_mode) begin
                word <= dat_s2;
              end else if (half) begin
                word[31:16] <= dat_s2[15:0];
              end else begin
                word[15:0] <= dat_s2[15:0];
              end
            end
            cnt <= 4'h0;
            state <= hpp_pkg::HPP_H_GAP;
          end
        end
        hpp_pkg::HPP_H_GAP: begin
          cnt <= cnt + 4'h1;
          if (cnt >= 4'(hpp_pkg::STB_HIGH_CYC - 1)) begin
            bus.host_data_oe <= 1'b0;
            if (halfword_bus_mode & ~half) begin
              half <= 1'b1;
              state <= hpp_pkg::HPP_H_SETUP;
            end else begin
              bus.host_chip_select_n <= 1'b1;
              rsp_valid <= 1'b1;
              rsp_data <= word;
              state <= hpp_pkg::HPP_H_IDLE;
            end
          end
        end
        default: begin
          state <= hpp_pkg::HPP_H_IDLE;
        end
      endcase
    end
  end

endmodule : hpp_host

// ### hpp_if.sv
`timescale 1ns/1ps
interface hpp_if;
  logic host_chip_select_n;
  logic host_data_strobe_a;
  logic host_data_strobe_b;
  logic host_address_strobe_n;
  logic [1:0] access_control_field;
  logic host_read_write;
  logic halfword_select;
  logic [31:0] host_data_out;
  logic host_data_oe;
  logic [31:0] dev_data_out;
  logic dev_data_oe;
  logic host_ready_n;
  logic [31:0] host_data_bus;

  // ----------------------------------------------------------------
  // shared data wire, device drive wins during contention
  // ----------------------------------------------------------------
  assign host_data_bus = dev_data_oe ? dev_data_out :
                         (host_data_oe ? host_data_out : 32'h0000_0000);

  modport dev (
    input host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    input host_address_strobe_n, access_control_field, host_read_write,
    input halfword_select, host_data_bus,
    output dev_data_out, dev_data_oe, host_ready_n
  );

  modport host (
    output host_chip_select_n, host_data_strobe_a, host_data_strobe_b,
    output host_address_strobe_n, access_control_field, host_read_write,
    output halfword_select, host_data_out, host_data_oe,
    input host_data_bus, host_ready_n
  );
endinterface : hpp_if

// ### hpp_pkg.sv
package hpp_pkg;

  // ----------------------------------------------------------------
  // widths and pin defaults
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int PIN_W = 8;
  // {chip_select_n, strobe_a, strobe_b, addr_strobe_n, rw, hws, ctl[1:0]}
  localparam logic [7:0] PIN_IDLE = 8'hf0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // access control field codes, bit 1 marks the data register
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_CONTROL = 2'h0;
  localparam logic [1:0] CTL_ADDRESS = 2'h1;
  localparam logic [1:0] CTL_DATA_INC = 2'h2;
  localparam logic [1:0] CTL_DATA = 2'h3;
  localparam int CTL_DATA_BIT = 1;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------
  // timing, cpu clock period equals mclk period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 50000;
  localparam int STB_LOW_MIN_PS = 12500;
  localparam int STB_LOW_MIN_P = 4;
  localparam int STB_HIGH_MIN_P = 4;
  localparam int STB_LOW_PS_CYC = (STB_LOW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_LOW_CYC =
    (STB_LOW_PS_CYC > STB_LOW_MIN_P) ? STB_LOW_PS_CYC : STB_LOW_MIN_P;
  localparam int STB_HIGH_CYC = STB_HIGH_MIN_P;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    HPP_ST_IDLE = 4'b0001,
    HPP_ST_FETCH = 4'b0010,
    HPP_ST_WAIT_WR = 4'b0100,
    HPP_ST_READY = 4'b1000
  } hpp_dev_state_t;

  typedef enum logic [3:0] {
    HPP_H_IDLE = 4'b0001,
    HPP_H_SETUP = 4'b0010,
    HPP_H_LOW = 4'b0100,
    HPP_H_GAP = 4'b1000
  } hpp_host_state_t;

endpackage : hpp_pkg
